// ===== dv/ceis_far_end.sv
// Model of the chipset and debug probe that drive the sideband pins.
`timescale 1ns/1ps
module ceis_far_end (
   // Bus clock.
   input wire logic mclk_in,
   // Pins: stop, probe, hard reset, bus init, soft init, ignore error.
   output logic [5:0] pins_n_out
);
   // Every pin idles inactive, which is high on this active-low sideband.
   initial begin
      pins_n_out = 6'h3F;
   end

   // Pins move on a falling edge of the bus clock, half a cycle ahead of the
   // device's rising-edge sampling; the device still synchronises them before use.
   task automatic drive(input int idx, input logic lvl);
      @(negedge mclk_in);
      pins_n_out[idx] = lvl;
   endtask
endmodule

// ===== dv/cpu_error_init_sideband_test.sv
// Self-checking bench for the error and initialisation sideband block.
`timescale 1ns/1ps
module cpu_error_init_sideband_test;
   // Clock, reset and core-side stimulus.
   logic mclk, rst, fpe_n, fclr, internal_error_out_ev, insn, ne_bit, snoop;
   // Far-end pins and device outputs.
   logic [5:0] pins_n;
   logic ferr_n, internal_error_out_n, shut, exc, cont, irr, cinv, bist, snp, xrv;
   int n_exec = 0;
   // Expected output pictures, oldest first.
   logic [6:0] exp_q[$];
   logic [6:0] obs, prev;
   int fail_count = 0, n_checks = 0, seed = 61, cyc = 0, w;
   // The watched picture: both sideband pins, then shutdown, exception, continue, self-test and snoop service.
   assign obs = {ferr_n, internal_error_out_n, shut, exc, cont, bist, snp};

   ceis_far_end u_far (.mclk_in(mclk), .pins_n_out(pins_n));
   ceis_sideband u_dut (
      .mclk_in(mclk), .rst_in(rst),
      .stop_clock_request_n_in(pins_n[0]), .probe_request_n_in(pins_n[1]),
      .hard_reset_n_in(pins_n[2]), .bus_initialise_n_in(pins_n[3]),
      .soft_init_n_in(pins_n[4]), .ignore_numeric_error_n_in(pins_n[5]),
      .fp_unmasked_error_n_in(fpe_n), .fp_error_clear_in(fclr),
      .internal_error_event_in(internal_error_out_ev), .fp_noncontrol_insn_in(insn),
      .numeric_error_enable_bit_in(ne_bit), .snoop_request_in(snoop),
      .fp_error_break_n_out(ferr_n), .internal_error_n_out(internal_error_out_n),
      .shutdown_request_out(shut), .fp_exception_out(exc),
      .fp_continue_out(cont), .int_regs_reset_out(irr),
      .exec_from_reset_vector_out(xrv), .cache_invalidate_out(cinv),
      .self_test_start_out(bist), .snoop_service_out(snp));

   // Free-running bus clock of 8 ns.
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Compares one value and counts the outcome.
   task automatic chk(input logic [6:0] got, input logic [6:0] want);
      n_checks++;
      if (got !== want) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask

   // Waits a number of falling edges.
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // One-cycle high pulse on a core-side input.
   task automatic pulse(ref logic s);
      @(negedge mclk);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
   endtask

   // A hang is cut short well past the few hundred cycles the run needs.
   always @(posedge mclk) begin
      cyc++;
      if (!rst && xrv === 1'b1) n_exec++;
      if (cyc == 3000) begin
         fail_count++;
         final_report();
      end
   end

   // Takes the oldest note each time the output picture moves; sampling
   // on the falling edge keeps clear of the design's update edge.
   always @(negedge mclk) begin
      if (!rst && obs !== prev) begin
         if (exp_q.size() == 0) begin
            chk(obs, ~obs);
         end else begin
            chk(obs, exp_q.pop_front());
         end
         prev = obs;
      end
   end

   // Main sequence.
   initial begin
      rst = 1'b1;
      {fpe_n, fclr, internal_error_out_ev, insn, ne_bit, snoop} = 6'h20;
      prev = 7'h60;
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      idle(3);
      chk(obs, 7'h60);
      // Unmasked error with no stop-clock drives the shared output low.
      exp_q.push_back(7'h20);
      fpe_n = 1'b0;
      idle(6);
      // Ignore input inactive, so the next instruction traps.
      exp_q.push_back(7'h28);
      exp_q.push_back(7'h20);
      pulse(insn);
      u_far.drive(5, 1'b0);
      idle(5);
      exp_q.push_back(7'h24);
      exp_q.push_back(7'h20);
      pulse(insn);
      // Enable bit set overrides the ignore input, so it traps again.
      ne_bit = 1'b1;
      exp_q.push_back(7'h28);
      exp_q.push_back(7'h20);
      pulse(insn);
      ne_bit = 1'b0;
      u_far.drive(5, 1'b1);
      exp_q.push_back(7'h60);
      fpe_n = 1'b1;
      idle(6);
      pulse(fclr);
      // Stop-clock alone changes nothing; probe under it is a break held
      // until stop-clock goes away, whatever the probe does meanwhile.
      for (int k = 0; k < 3; k++) begin
         w = 3 + ($unsigned($random(seed)) % 5);
         u_far.drive(0, 1'b0);
         idle(w);
         exp_q.push_back(7'h20);
         u_far.drive(1, 1'b0);
         idle(5);
         u_far.drive(1, 1'b1);
         idle(w);
         exp_q.push_back(7'h60);
         u_far.drive(0, 1'b1);
         idle(6);
      end
      // Internal error is held until each reset-class input in turn.
      for (int k = 2; k < 5; k++) begin
         exp_q.push_back(7'h50);
         exp_q.push_back(7'h40);
         pulse(internal_error_out_ev);
         idle(8);
         exp_q.push_back(7'h60);
         u_far.drive(k, 1'b0);
         idle(5);
         if (k == 4) chk({6'h00, irr}, 7'h01);
         if (k == 4) chk({6'h00, cinv}, 7'h00);
         if (k == 2) chk({6'h00, cinv}, 7'h01);
         u_far.drive(k, 1'b1);
         idle(6);
      end
      // Snoops at random spacing outside soft init are served too.
      for (int k = 0; k < 6; k++) begin
         if ($random(seed) & 1) begin
            exp_q.push_back(7'h61);
            exp_q.push_back(7'h60);
            pulse(snoop);
         end
         idle(2);
      end
      // Snoops are still served under soft init, and soft init held
      // across the release of hard reset starts self-test.
      u_far.drive(4, 1'b0);
      idle(5);
      exp_q.push_back(7'h61);
      exp_q.push_back(7'h60);
      pulse(snoop);
      u_far.drive(2, 1'b0);
      idle(5);
      exp_q.push_back(7'h62);
      exp_q.push_back(7'h60);
      u_far.drive(2, 1'b1);
      idle(6);
      u_far.drive(4, 1'b1);
      idle(6);
      chk(7'(exp_q.size()), 7'h00);
      // Two hard-reset releases and two soft-init releases restart.
      chk(7'(n_exec), 7'h04);
      final_report();
   end
endmodule

// ===== logic/ceis_pkg.sv
// Package of constants for the error and initialisation sideband block.
package ceis_pkg;
   // Number of flip-flops in each input synchroniser.
   localparam int SYNC_STAGES = 2;
   // Number of inputs that are synchronised: six sideband pins and the core's FP error level.
   localparam int NUM_INPUTS = 7;
   // Bit positions of the inputs in the synchronised vector.
   localparam int IDX_STOP_CLK = 0;
   localparam int IDX_PROBE = 1;
   localparam int IDX_HARD_RST = 2;
   localparam int IDX_BUS_INIT = 3;
   localparam int IDX_SOFT_INIT = 4;
   localparam int IDX_IGNORE_NE = 5;
   localparam int IDX_FP_ERR = 6;
   // Reset value of the synchronisers: every active-low input idles high.
   localparam logic [6:0] SYNC_RESET = 7'h7F;
   // State of the multiplexed error/break output.
   typedef enum logic [1:0] {
      CEIS_FERR_IDLE = 2'b00,
      CEIS_FERR_ERROR = 2'b01,
      CEIS_FERR_BREAK = 2'b10
   } ceis_ferr_state_t;
endpackage

// ===== logic/ceis_sideband.sv
// Error, break and initialisation sideband logic of the processor.
`timescale 1ns/1ps
// Contract
// RL1: Report unmasked FP error when no stop-clock
// RL2: During stop-clock, output shows pending break
// RL3: Break indication held until stop-clock drops
// RL4: Probe request under stop-clock is break
// RL5: Internal error asserts output, requests shutdown
// RL6: Internal error held until reset-class input
// RL7: Ignore-numeric-error lets FP instructions continue
// RL8: Otherwise pending FP error raises exception
// RL9: Numeric-error enable bit overrides ignore input
// RL10: Other party drives inputs valid by target-ready
// RL11: Soft init resets integer state, keeps caches
// RL12: Snoops keep being serviced during soft init
// RL13: Soft init at hard-reset release runs self-test
// RL14: Hard reset invalidates caches without writeback
// RL15: Sideband active low, inputs synchronised
module ceis_sideband (
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic rst_in,
   // Asynchronous sideband pins, active low.
   input wire logic stop_clock_request_n_in,
   input wire logic probe_request_n_in,
   input wire logic hard_reset_n_in,
   input wire logic bus_initialise_n_in,
   input wire logic soft_init_n_in,
   input wire logic ignore_numeric_error_n_in,
   // Core-side events, synchronous one-cycle pulses or levels.
   input wire logic fp_unmasked_error_n_in,
   input wire logic fp_error_clear_in,
   input wire logic internal_error_event_in,
   input wire logic fp_noncontrol_insn_in,
   input wire logic numeric_error_enable_bit_in,
   input wire logic snoop_request_in,
   // Sideband outputs, active low.
   output logic fp_error_break_n_out,
   output logic internal_error_n_out,
   // Core control outputs.
   output logic shutdown_request_out,
   output logic fp_exception_out,
   output logic fp_continue_out,
   output logic int_regs_reset_out,
   output logic exec_from_reset_vector_out,
   output logic cache_invalidate_out,
   output logic self_test_start_out,
   output logic snoop_service_out
);
   // Synchronised inputs, active low. Every pin, even the core's FP
   // error level, takes the same two-flop path, so the decisions below
   // see one consistent snapshot at the cost of two cycles of lag.
   logic [ceis_pkg::NUM_INPUTS-1:0] raw_n;
   logic [ceis_pkg::NUM_INPUTS-1:0] syn_n;

   // The FP error level arrives from the core; it goes through the bank
   // too so it lines up in time with the six sideband pins.
   assign raw_n = {fp_unmasked_error_n_in, ignore_numeric_error_n_in,
                   soft_init_n_in, bus_initialise_n_in, hard_reset_n_in,
                   probe_request_n_in, stop_clock_request_n_in};

   ceis_sync u_sync (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .async_n_in(raw_n),
      .sync_n_out(syn_n)
   );

   // Active-high decoded views of the synchronised pins.
   wire stop_clk = ~syn_n[ceis_pkg::IDX_STOP_CLK]; // RL15
   wire probe = ~syn_n[ceis_pkg::IDX_PROBE];
   wire hard_rst = ~syn_n[ceis_pkg::IDX_HARD_RST];
   wire bus_init = ~syn_n[ceis_pkg::IDX_BUS_INIT];
   wire soft_init = ~syn_n[ceis_pkg::IDX_SOFT_INIT];
   wire ignore_ne = ~syn_n[ceis_pkg::IDX_IGNORE_NE];
   wire fp_err = ~syn_n[ceis_pkg::IDX_FP_ERR];

   // Any reset-class input clears the internal-error indication.
   wire internal_error_out_clear = hard_rst | bus_init | soft_init; // RL6

   // Ignore input is honoured only while the enable bit is clear.
   wire ignore_eff = ignore_ne & ~numeric_error_enable_bit_in; // RL9

   // Break source while stop-clock is active. A probe request is the
   // only break source handled here; any further break source of the
   // core would be ORed into this term.
   wire break_evt = stop_clk & probe; // RL4

   // Pending-error flag, exception and continue decisions.
   logic fp_pending_r;
   logic fp_pending_nxt;
   wire fp_raise = fp_noncontrol_insn_in & fp_pending_r & ~ignore_eff;
   wire fp_go = fp_noncontrol_insn_in & (~fp_pending_r | ignore_eff);

   // Set wins over the clear so an error in the clearing cycle survives.
   assign fp_pending_nxt = fp_err ? 1'b1 :
                           (fp_error_clear_in ? 1'b0 : fp_pending_r);

   // Multiplexed output state.
   ceis_pkg::ceis_ferr_state_t ferr_r;
   ceis_pkg::ceis_ferr_state_t ferr_nxt;

   // Choose what the multiplexed pin reports next.
   always_comb begin
      case (ferr_r)
         ceis_pkg::CEIS_FERR_IDLE: begin
            if (break_evt) begin
               ferr_nxt = ceis_pkg::CEIS_FERR_BREAK; // RL2
            end else if (!stop_clk && fp_err) begin
               ferr_nxt = ceis_pkg::CEIS_FERR_ERROR; // RL1
            end else begin
               ferr_nxt = ceis_pkg::CEIS_FERR_IDLE;
            end
         end
         ceis_pkg::CEIS_FERR_ERROR: begin
            // Error is qualified by stop-clock; a break takes over.
            if (break_evt) begin
               ferr_nxt = ceis_pkg::CEIS_FERR_BREAK; // RL2
            end else if (!stop_clk && fp_err) begin
               ferr_nxt = ceis_pkg::CEIS_FERR_ERROR; // RL1
            end else begin
               ferr_nxt = ceis_pkg::CEIS_FERR_IDLE;
            end
         end
         ceis_pkg::CEIS_FERR_BREAK: begin
            // Held until stop-clock is released.
            if (stop_clk) begin
               ferr_nxt = ceis_pkg::CEIS_FERR_BREAK; // RL3
            end else begin
               ferr_nxt = ceis_pkg::CEIS_FERR_IDLE;
            end
         end
         default: begin
            ferr_nxt = ceis_pkg::CEIS_FERR_IDLE;
         end
      endcase
   end

   // Internal-error latch: set wins over a simultaneous clear. Losing
   // an error that lands in the clearing cycle would hide a fault, so
   // the output is kept low for that new error instead.
   logic internal_error_out_r;
   wire internal_error_out_nxt = internal_error_event_in | (internal_error_out_r & ~internal_error_out_clear);

   // Hard-reset edge tracking for the self-test strap.
   logic hard_rst_d_r;
   wire hard_rst_release = hard_rst_d_r & ~hard_rst;

   // Soft-init edge tracking: the core restarts once the pin lets go.
   logic soft_init_d_r;
   wire soft_init_release = soft_init_d_r & ~soft_init;

   // State registers. The edge trackers reset to the inactive level of
   // their synchronised pins, so no false release follows a reset.
   // The pending FP flag is dropped on hard reset as well.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ferr_r <= ceis_pkg::CEIS_FERR_IDLE;
         internal_error_out_r <= 1'b0;
         fp_pending_r <= 1'b0;
         hard_rst_d_r <= 1'b0;
         soft_init_d_r <= 1'b0;
      end else begin
         ferr_r <= ferr_nxt;
         internal_error_out_r <= internal_error_out_nxt; // RL6
         fp_pending_r <= hard_rst ? 1'b0 : fp_pending_nxt;
         hard_rst_d_r <= hard_rst;
         soft_init_d_r <= soft_init;
      end
   end

   // Registered outputs, all driven from reset onward. Each comes
   // straight from a flop, so no decode glitch can reach the core or
   // the chipset.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         fp_error_break_n_out <= 1'b1;
         internal_error_n_out <= 1'b1;
         shutdown_request_out <= 1'b0;
         fp_exception_out <= 1'b0;
         fp_continue_out <= 1'b0;
         int_regs_reset_out <= 1'b0;
         exec_from_reset_vector_out <= 1'b0;
         cache_invalidate_out <= 1'b0;
         self_test_start_out <= 1'b0;
         snoop_service_out <= 1'b0;
      end else begin
         fp_error_break_n_out <= (ferr_nxt == ceis_pkg::CEIS_FERR_IDLE);
         internal_error_n_out <= ~internal_error_out_nxt; // RL5
         // One shutdown pulse on the first cycle of an internal error.
         shutdown_request_out <= internal_error_event_in & ~internal_error_out_r; // RL5
         fp_exception_out <= fp_raise; // RL8
         fp_continue_out <= fp_go; // RL7
         // Soft init clears integer state only; caches stay untouched.
         int_regs_reset_out <= soft_init | hard_rst; // RL11
         // Restart at the reset vector as soft init or hard reset ends.
         exec_from_reset_vector_out <= hard_rst_release |
            soft_init_release; // RL11
         // Caches are dropped only on hard reset, with no writeback.
         cache_invalidate_out <= hard_rst; // RL14
         // Soft init seen at the hard-reset release starts self-test.
         self_test_start_out <= hard_rst_release & soft_init; // RL13
         // Snoops are still served while soft init is held.
         snoop_service_out <= snoop_request_in & ~hard_rst; // RL12
      end
   end

   // Assertions. They watch the synchronised views, so each one speaks
   // of the cycle after the decision, which is when the registered
   // outputs show it. Raw pins are not checked here: their timing
   // against the clock is the far side's business.
   // All properties share the bus clock and the block reset.
   a_break_holds: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ferr_r == ceis_pkg::CEIS_FERR_BREAK && stop_clk)
      |=> !fp_error_break_n_out) // RL3
      else $error("break indication dropped under stop-clock");
   a_probe_break: assert property (@(posedge mclk_in) disable iff (rst_in)
      break_evt |=> !fp_error_break_n_out) // RL4
      else $error("probe under stop-clock not reported");
   a_fp_error_out: assert property (@(posedge mclk_in) disable iff (rst_in)
      (!stop_clk && fp_err) |=> !fp_error_break_n_out) // RL1
      else $error("unmasked fp error not reported");
   a_break_release: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ferr_r == ceis_pkg::CEIS_FERR_BREAK && !stop_clk && !fp_err)
      |=> fp_error_break_n_out) // RL2
      else $error("break output stuck after stop-clock release");
   a_internal_error_out_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
      internal_error_event_in |=> !internal_error_n_out) // RL5
      else $error("internal error not asserted");
   a_internal_error_out_holds: assert property (@(posedge mclk_in) disable iff (rst_in)
      (!internal_error_n_out && !internal_error_out_clear && !internal_error_event_in)
      |=> !internal_error_n_out) // RL6
      else $error("internal error released without reset input");
   a_internal_error_out_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
      (internal_error_out_clear && !internal_error_event_in) |=> internal_error_n_out) // RL6
      else $error("internal error not cleared");
   a_ignore_mask: assert property (@(posedge mclk_in) disable iff (rst_in)
      (numeric_error_enable_bit_in && fp_pending_r && fp_noncontrol_insn_in)
      |=> fp_exception_out) // RL9
      else $error("ignore input not disregarded");
   a_ignore_go: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ignore_eff && fp_noncontrol_insn_in)
      |=> (fp_continue_out && !fp_exception_out)) // RL7
      else $error("ignored error still raised exception");
   a_self_test: assert property (@(posedge mclk_in) disable iff (rst_in)
      (hard_rst_release && soft_init) |=> self_test_start_out) // RL13
      else $error("self-test not started");
   a_soft_snoop: assert property (@(posedge mclk_in) disable iff (rst_in)
      (soft_init && !hard_rst && snoop_request_in)
      |=> (snoop_service_out && !cache_invalidate_out)) // RL12
      else $error("snoop dropped during soft init");

   // Without a snoop request nothing is reported as serviced.
   a_snoop_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
      !snoop_request_in |=> !snoop_service_out) // RL12
      else $error("snoop service without a request");

   // Shutdown is requested once, not for the whole error.
   a_shutdown_once: assert property (@(posedge mclk_in) disable iff (rst_in)
      shutdown_request_out |=> !shutdown_request_out) // RL5
      else $error("shutdown request longer than one cycle");

   // With the ignore pin inactive a pending error traps.
   a_fp_trap: assert property (@(posedge mclk_in) disable iff (rst_in)
      (fp_noncontrol_insn_in && fp_pending_r && !ignore_ne)
      |=> (fp_exception_out && !fp_continue_out)) // RL8
      else $error("pending fp error did not trap");

   // Stop-clock without a break keeps the shared pin high.
   a_break_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
      (stop_clk && !break_evt && ferr_r != ceis_pkg::CEIS_FERR_BREAK)
      |=> fp_error_break_n_out) // RL2
      else $error("shared pin low under stop-clock without break");

   // Soft init resets the integer registers.
   a_int_regs: assert property (@(posedge mclk_in) disable iff (rst_in)
      soft_init |=> int_regs_reset_out) // RL11
      else $error("integer registers not reset on soft init");

   // Soft init leaves the caches alone.
   a_cache_keep: assert property (@(posedge mclk_in) disable iff (rst_in)
      (soft_init && !hard_rst) |=> !cache_invalidate_out) // RL11
      else $error("caches touched by soft init");

   // The end of soft init restarts at the reset vector.
   a_exec_vector: assert property (@(posedge mclk_in) disable iff (rst_in)
      (soft_init_d_r && !soft_init) |=> exec_from_reset_vector_out) // RL11
      else $error("no restart after soft init");

   // Hard reset drops the caches.
   a_cache_drop: assert property (@(posedge mclk_in) disable iff (rst_in)
      hard_rst |=> cache_invalidate_out) // RL14
      else $error("caches kept under hard reset");

   c_break: cover property (@(posedge mclk_in) disable iff (rst_in)
      ferr_r == ceis_pkg::CEIS_FERR_BREAK);
   c_error: cover property (@(posedge mclk_in) disable iff (rst_in)
      ferr_r == ceis_pkg::CEIS_FERR_ERROR);
   c_internal_error_out_clear: cover property (@(posedge mclk_in) disable iff (rst_in)
      internal_error_out_r && internal_error_out_clear);
   c_bist: cover property (@(posedge mclk_in) disable iff (rst_in)
      self_test_start_out);
   c_restart: cover property (@(posedge mclk_in) disable iff (rst_in)
      exec_from_reset_vector_out);
endmodule

// ===== logic/ceis_sync.sv
// Two-flop synchroniser bank for active-low asynchronous sideband inputs.
`timescale 1ns/1ps
module ceis_sync (
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic rst_in,
   // Raw asynchronous inputs, active low.
   input wire logic [ceis_pkg::NUM_INPUTS-1:0] async_n_in,
   // Synchronised inputs, active low.
   output logic [ceis_pkg::NUM_INPUTS-1:0] sync_n_out
);
   // First stage is read only by the second stage.
   logic [ceis_pkg::NUM_INPUTS-1:0] meta_r;

   // Each bit passes through two flops; reset idles them inactive.
   genvar gi;
   generate
      for (gi = 0; gi < ceis_pkg::NUM_INPUTS; gi = gi + 1) begin : g_bit
         always_ff @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
               meta_r[gi] <= ceis_pkg::SYNC_RESET[gi];
               sync_n_out[gi] <= ceis_pkg::SYNC_RESET[gi];
            end else begin
               meta_r[gi] <= async_n_in[gi]; // RL15
               sync_n_out[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate
endmodule
